// ==== ram_block_consts.svh ====
/*
 * constants of the embedded synchronous ram block: array size, widths,
 * lane layout and port-width codes.
 * assumes inclusion by name from the package and the design modules.
 */
`ifndef RAM_BLOCK_CONSTS_SVH
`define RAM_BLOCK_CONSTS_SVH

`define ARRAY_BITS 4608
`define ARRAY_WORDS 128
`define ARRAY_WORD_W 36
`define HALF_WORDS 64
`define LINE_ADDR_W 7
`define BIT_ADDR_W 12
`define DATA_W 36
`define MASK_W 4
`define LANE8_W 8
`define LANE9_W 9
`define NARROW_W_MAX 9
`define PORT_W_MAX 18
`define MASK_ALL 4'hf
`define ADDR_ZERO 12'h000
`define DATA_ZERO 36'h0

// port width codes
`define W_X1 4'h0
`define W_X2 4'h1
`define W_X4 4'h2
`define W_X8 4'h3
`define W_X9 4'h4
`define W_X16 4'h5
`define W_X18 4'h6
`define W_X32 4'h7
`define W_X36 4'h8

`endif

// ==== ram_block_pkg.sv ====
/*
 * types of the embedded synchronous ram block.
 * assumes ram_block_consts.svh is on the include path.
 */
`include "ram_block_consts.svh"

package ram_block_pkg;

    typedef enum logic [1:0] {
        mode_single,
        mode_packed,
        mode_true_dual
    } ram_mode_t;

    typedef logic [3:0] width_code_t;

    // one port request as the fabric presents it
    typedef struct packed {
        logic [`BIT_ADDR_W-1:0] addr;
        logic [`DATA_W-1:0] wdata;
        logic wren;
        logic rden;
        logic [`MASK_W-1:0] lane_mask;
        logic addr_hold;
    } port_req_t;

    // captured request after the input registers
    typedef struct packed {
        logic [`BIT_ADDR_W-1:0] addr;
        logic [`DATA_W-1:0] wdata;
        logic wren;
        logic rden;
        logic [`MASK_W-1:0] lane_mask;
    } port_cap_t;

endpackage

// ==== ram_port_lanes.sv ====
/*
 * lane decode for one port: maps a captured address and width to the
 * array line, the bit offset in the line, and a per-bit write mask.
 * assumes the port width code is static while the block runs.
 */
`timescale 1ns/1ps
`include "ram_block_consts.svh"

module ram_port_lanes
    import ram_block_pkg::*;
(
    input wire width_code_t width_in,
    input wire logic [`BIT_ADDR_W-1:0] addr_in,
    input wire logic [`MASK_W-1:0] mask_in,
    input wire logic upper_half_in,
    output logic [`LINE_ADDR_W-1:0] line_out,
    output logic [5:0] offset_out,
    output logic [`ARRAY_WORD_W-1:0] bit_mask_out
);

    // data width from the width code
    function automatic logic [5:0] width_bits(input width_code_t w);
        case (w)
            `W_X1: width_bits = 6'h01;
            `W_X2: width_bits = 6'h02;
            `W_X4: width_bits = 6'h04;
            `W_X8: width_bits = 6'h08;
            `W_X9: width_bits = 6'h09;
            `W_X16: width_bits = 6'h10;
            `W_X18: width_bits = 6'h12;
            `W_X32: width_bits = 6'h20;
            default: width_bits = 6'h24;
        endcase
    endfunction

    // slots per 36-bit line for the width (9-bit family packs 4 lanes, 8-bit family 4 bytes)
    function automatic logic [5:0] slots(input width_code_t w);
        case (w)
            `W_X1: slots = 6'h20;
            `W_X2: slots = 6'h10;
            `W_X4: slots = 6'h08;
            `W_X8, `W_X9: slots = 6'h04;
            `W_X16, `W_X18: slots = 6'h02;
            default: slots = 6'h01;
        endcase
    endfunction

    wire logic [5:0] wbits = width_bits(width_in);
    wire logic [5:0] nslot = slots(width_in);
    wire logic nine_family = (width_in == `W_X9) || (width_in == `W_X18) || (width_in == `W_X36);
    wire logic [5:0] lane_w = nine_family ? 6'(`LANE9_W) : 6'(`LANE8_W);
    wire logic [11:0] slot_idx = addr_in % 12'(nslot);
    wire logic [11:0] line_idx = addr_in / 12'(nslot);

    // packed half selects the upper 64 lines
    assign line_out = upper_half_in ? {1'b1, line_idx[5:0]} : line_idx[`LINE_ADDR_W-1:0];
    assign offset_out = 6'(slot_idx * 12'(wbits));

    // per-bit write mask; narrow widths use mask bit 0 for the whole word
    genvar b;
    generate
        for (b = 0; b < `ARRAY_WORD_W; b++) begin : g_bit
            wire logic [5:0] rel = 6'(b) - offset_out;
            wire logic inside_word = (6'(b) >= offset_out) && (rel < wbits);
            wire logic [1:0] lane = (wbits <= 6'(`NARROW_W_MAX)) ? 2'h0 : 2'(rel / lane_w);
            assign bit_mask_out[b] = inside_word && mask_in[lane];
        end
    endgenerate

endmodule

// ==== embedded_sync_ram_block.sv ====
/*
 * embedded synchronous ram block: 4608-bit array with two ports, registered
 * inputs, per-lane write masking, address hold, packed and true dual-port
 * use, flow-through or registered read data.
 * assumes one fabric clock, inputs synchronous to it, and static
 * configuration inputs (mode, widths, output register select).
 */
`timescale 1ns/1ps
`include "ram_block_consts.svh"

module embedded_sync_ram_block
    import ram_block_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic block_en_in,
    input wire logic out_clr_in,
    input wire ram_mode_t mode_in,
    input wire width_code_t width_a_in,
    input wire width_code_t width_b_in,
    input wire logic out_reg_en_in,
    input wire port_req_t req_a_in,
    input wire port_req_t req_b_in,
    output logic [`DATA_W-1:0] rdata_a_out,
    output logic [`DATA_W-1:0] rdata_b_out
);

    // reset release through two flip-flops
    logic rst_meta;
    logic rst_sync;
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end
    wire logic rstn = rst_sync;

    // gated block clock: no edge reaches the block while disabled
    logic en_latch;
    always_latch begin
        if (!core_clk_in) begin
            en_latch = block_en_in;
        end
    end
    wire logic blk_clk = core_clk_in & en_latch;

    // configuration helpers
    wire logic is_dual = (mode_in == mode_true_dual);
    wire logic is_packed = (mode_in == mode_packed);
    wire logic port_b_live = is_dual || is_packed;

    // legal width per mode; dual and packed ports at most 18 bits
    function automatic logic width_ok(input width_code_t w, input logic narrow);
        logic ok;
        ok = (w <= `W_X36);
        if (narrow) begin
            ok = ok && (w != `W_X32) && (w != `W_X36);
        end
        width_ok = ok;
    endfunction

    wire logic a_ok = width_ok(width_a_in, port_b_live);
    wire logic b_ok = width_ok(width_b_in, 1'b1) && port_b_live;

    // mask split per port in dual use; otherwise full mask on port a
    wire logic [`MASK_W-1:0] mask_a_src = is_dual ? {2'h0, req_a_in.lane_mask[1:0]} : req_a_in.lane_mask;
    wire logic [`MASK_W-1:0] mask_b_src = is_dual ? {2'h0, req_a_in.lane_mask[3:2]} : req_b_in.lane_mask;

    // input registers: no asynchronous clear on these
    port_cap_t cap_a;
    port_cap_t cap_b;
    logic [`MASK_W-1:0] mask_a = `MASK_ALL;
    logic [`MASK_W-1:0] mask_b = `MASK_ALL;

    // address with hold feedback per port
    wire logic [`BIT_ADDR_W-1:0] next_addr_a = req_a_in.addr_hold ? cap_a.addr : req_a_in.addr;
    wire logic [`BIT_ADDR_W-1:0] next_addr_b = req_b_in.addr_hold ? cap_b.addr : req_b_in.addr;

    always_ff @(posedge blk_clk) begin
        cap_a.addr <= next_addr_a;
        cap_a.wdata <= req_a_in.wdata;
        cap_a.wren <= req_a_in.wren && rstn && a_ok;
        cap_a.rden <= req_a_in.rden && !req_a_in.wren && rstn;
        cap_a.lane_mask <= mask_a_src;
        cap_b.addr <= next_addr_b;
        cap_b.wdata <= req_b_in.wdata;
        cap_b.wren <= req_b_in.wren && rstn && b_ok;
        cap_b.rden <= req_b_in.rden && !req_b_in.wren && rstn && port_b_live;
        cap_b.lane_mask <= mask_b_src;
    end

    // lane mask registers: clock-loaded only, start at all ones
    always_ff @(posedge blk_clk) begin
        mask_a <= cap_a.lane_mask;
        mask_b <= cap_b.lane_mask;
    end

    // lane decode per port
    logic [`LINE_ADDR_W-1:0] line_a;
    logic [`LINE_ADDR_W-1:0] line_b;
    logic [5:0] off_a;
    logic [5:0] off_b;
    logic [`ARRAY_WORD_W-1:0] bm_a;
    logic [`ARRAY_WORD_W-1:0] bm_b;

    ram_port_lanes u_lanes_a (
        .width_in(width_a_in),
        .addr_in(cap_a.addr),
        .mask_in(cap_a.lane_mask),
        .upper_half_in(1'b0),
        .line_out(line_a),
        .offset_out(off_a),
        .bit_mask_out(bm_a)
    );

    ram_port_lanes u_lanes_b (
        .width_in(width_b_in),
        .addr_in(cap_b.addr),
        .mask_in(cap_b.lane_mask),
        .upper_half_in(is_packed),
        .line_out(line_b),
        .offset_out(off_b),
        .bit_mask_out(bm_b)
    );

    // packed port a stays in the lower half
    wire logic [`LINE_ADDR_W-1:0] line_a_eff = is_packed ? {1'b0, line_a[5:0]} : line_a;

    // storage array
    logic [`ARRAY_WORD_W-1:0] mem [`ARRAY_WORDS];

    // shifted write data per port
    wire logic [`ARRAY_WORD_W-1:0] wd_a = `ARRAY_WORD_W'(cap_a.wdata << off_a);
    wire logic [`ARRAY_WORD_W-1:0] wd_b = `ARRAY_WORD_W'(cap_b.wdata << off_b);

    // current line contents
    wire logic [`ARRAY_WORD_W-1:0] old_a = mem[line_a_eff];
    wire logic [`ARRAY_WORD_W-1:0] old_b = mem[line_b];

    // merged line: only masked-in bits change
    wire logic [`ARRAY_WORD_W-1:0] new_a = (old_a & ~bm_a) | (wd_a & bm_a);
    wire logic [`ARRAY_WORD_W-1:0] new_b = (old_b & ~bm_b) | (wd_b & bm_b);

    // array write; when both ports write the same line, port a wins and the port b write is dropped
    always_ff @(posedge blk_clk) begin
        if (cap_a.wren) begin
            mem[line_a_eff] <= new_a;
        end
        if (cap_b.wren && !(cap_a.wren && line_b == line_a_eff)) begin
            mem[line_b] <= new_b;
        end
    end

    // read path: flow-through on write, array value on read
    wire logic [`ARRAY_WORD_W-1:0] rline_a = cap_a.wren ? new_a : old_a;
    wire logic [`ARRAY_WORD_W-1:0] rline_b = cap_b.wren ? new_b : old_b;
    wire logic [`DATA_W-1:0] word_a = `DATA_W'(rline_a >> off_a);
    wire logic [`DATA_W-1:0] word_b = `DATA_W'(rline_b >> off_b);

    // unmasked lanes during a write show stale data, treated as don't-care
    wire logic upd_a = cap_a.wren || cap_a.rden;
    wire logic upd_b = cap_b.wren || cap_b.rden;

    // flow-through hold registers: keep last read or written word between accesses
    logic [`DATA_W-1:0] flow_a;
    logic [`DATA_W-1:0] flow_b;
    always_ff @(posedge blk_clk or negedge rstn_in) begin
        if (!rstn_in) begin
            flow_a <= `DATA_ZERO;
            flow_b <= `DATA_ZERO;
        end else begin
            if (upd_a) begin
                flow_a <= word_a;
            end
            if (upd_b) begin
                flow_b <= word_b;
            end
        end
    end
    wire logic [`DATA_W-1:0] ft_a = upd_a ? word_a : flow_a;
    wire logic [`DATA_W-1:0] ft_b = upd_b ? word_b : flow_b;

    // output registers: the only registers with an asynchronous clear from out_clr_in
    logic [`DATA_W-1:0] oreg_a;
    logic [`DATA_W-1:0] oreg_b;
    always_ff @(posedge blk_clk or posedge out_clr_in or negedge rstn_in) begin
        if (!rstn_in || out_clr_in) begin
            oreg_a <= `DATA_ZERO;
            oreg_b <= `DATA_ZERO;
        end else begin
            oreg_a <= ft_a;
            oreg_b <= ft_b;
        end
    end

    // pipelined or flow-through selection
    assign rdata_a_out = out_reg_en_in ? oreg_a : ft_a;
    assign rdata_b_out = out_reg_en_in ? oreg_b : ft_b;

    // checks
    chk_hold_keeps_addr: assert property (@(posedge blk_clk) disable iff (!rstn)
        req_a_in.addr_hold |=> cap_a.addr == $past(cap_a.addr))
        else $error("address hold did not keep address");
    chk_new_addr_taken: assert property (@(posedge blk_clk) disable iff (!rstn)
        !req_a_in.addr_hold |=> cap_a.addr == $past(req_a_in.addr))
        else $error("address not captured with hold low");
    chk_hold_port_b: assert property (@(posedge blk_clk) disable iff (!rstn)
        (req_b_in.addr_hold && !req_a_in.addr_hold) |=> cap_b.addr == $past(cap_b.addr))
        else $error("port b hold failed");
    chk_no_rw_both: assert property (@(posedge blk_clk) disable iff (!rstn)
        !(cap_a.wren && cap_a.rden))
        else $error("read and write together");
    chk_write_strobe: assert property (@(posedge blk_clk) disable iff (!rstn)
        !$past(req_a_in.wren) |-> !cap_a.wren)
        else $error("write without strobe");
    chk_masked_keep: assert property (@(posedge blk_clk) disable iff (!rstn)
        (cap_a.wren && !cap_b.wren) |=> ((mem[$past(line_a_eff)] & ~$past(bm_a)) == ($past(old_a) & ~$past(bm_a))))
        else $error("unmasked bits changed");
    chk_flow_new: assert property (@(posedge blk_clk) disable iff (!rstn)
        (cap_a.wren && !out_reg_en_in) |-> ((rdata_a_out << off_a) & bm_a) == (wd_a & bm_a))
        else $error("written lanes not on output");
    chk_dual_split: assert property (@(posedge blk_clk) disable iff (!rstn)
        is_dual |=> cap_b.lane_mask[1:0] == $past(req_a_in.lane_mask[3:2]))
        else $error("port b mask split wrong");
    chk_pipe_delay: assert property (@(posedge blk_clk) disable iff (!rstn || out_clr_in)
        (out_reg_en_in && !out_clr_in) ##1 (out_reg_en_in && !out_clr_in && !$rose(rstn)) |-> rdata_a_out == $past(ft_a))
        else $error("pipelined output not one cycle late");

endmodule

// ==== fabric_user.sv ====
/*
 * fabric-side user logic model: drives both port requests of the ram
 * block and samples the read data at the settled point of each access.
 * assumes one rising-edge clock shared with the block.
 */
`timescale 1ns/1ps
`include "ram_block_consts.svh"

module fabric_user
    import ram_block_pkg::*;
(
    input wire logic clk_in,
    input wire logic [`DATA_W-1:0] rdata_a_in,
    input wire logic [`DATA_W-1:0] rdata_b_in,
    output port_req_t req_a_out,
    output port_req_t req_b_out
);
    // quiet requests at time zero
    initial begin
        req_a_out = '0;
        req_b_out = '0;
    end

    // one access on both ports, then idle with stale data inverted
    task automatic cycle(input port_req_t a, input port_req_t b, input int lat,
                         output logic [`DATA_W-1:0] ra, output logic [`DATA_W-1:0] rb);
        port_req_t ia;
        port_req_t ib;
        ia = a;
        ib = b;
        ia.wren = 1'b0;
        ia.rden = 1'b0;
        ia.wdata = ~a.wdata;
        ia.addr_hold = 1'b0;
        ib.wren = 1'b0;
        ib.rden = 1'b0;
        ib.wdata = ~b.wdata;
        ib.addr_hold = 1'b0;
        @(posedge clk_in);
        req_a_out <= a;
        req_b_out <= b;
        @(posedge clk_in);
        req_a_out <= ia;
        req_b_out <= ib;
        repeat (lat) @(posedge clk_in);
        #1;
        ra = rdata_a_in;
        rb = rdata_b_in;
    endtask
endmodule

// ==== tb.sv ====
/*
 * testbench of the embedded ram block: masking, address hold, clock
 * enable, output clear, true dual-port and packed use.
 * assumes the design files and fabric_user.sv are compiled before it.
 */
`timescale 1ns/1ps
`include "ram_block_consts.svh"
`define CHECK_EQ(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin errors++; \
    $display("[FAIL] %s expected %h seen %h", what, exp, got); end end

module tb;
    import ram_block_pkg::*;
    logic core_clk_in, rstn_in, block_en_in, out_clr_in, out_reg_en_in;
    ram_mode_t mode_in;
    width_code_t width_a_in, width_b_in;
    port_req_t req_a_in, req_b_in, nob;
    logic [`DATA_W-1:0] rdata_a_out, rdata_b_out, d;
    int errors = 0;
    int n_compared = 0;
    int lat = 0;

    embedded_sync_ram_block i_dut (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
        .block_en_in(block_en_in), .out_clr_in(out_clr_in), .mode_in(mode_in),
        .width_a_in(width_a_in), .width_b_in(width_b_in), .out_reg_en_in(out_reg_en_in),
        .req_a_in(req_a_in), .req_b_in(req_b_in), .rdata_a_out(rdata_a_out), .rdata_b_out(rdata_b_out));
    fabric_user i_fab (.clk_in(core_clk_in), .rdata_a_in(rdata_a_out), .rdata_b_in(rdata_b_out),
        .req_a_out(req_a_in), .req_b_out(req_b_in));

    // 100 mhz clock
    initial core_clk_in = 1'b0;
    always #5 core_clk_in = ~core_clk_in;

    function automatic port_req_t mk(input logic [11:0] ad, input logic [35:0] wd, input logic we,
                                     input logic re, input logic [3:0] m, input logic h);
        mk = '{addr: ad, wdata: wd, wren: we, rden: re, lane_mask: m, addr_hold: h};
    endfunction

    // bit mask of 9-bit lanes
    function automatic logic [35:0] m9(input logic [3:0] m);
        m9 = '0;
        for (int i = 0; i < 4; i++) begin
            if (m[i]) m9[9*i +: 9] = 9'h1ff;
        end
    endfunction

    task automatic cfg(input ram_mode_t md, input width_code_t w, input logic oreg);
        @(posedge core_clk_in);
        rstn_in <= 1'b0;
        mode_in <= md;
        width_a_in <= w;
        width_b_in <= w;
        out_reg_en_in <= oreg;
        lat = oreg;
        repeat (5) @(posedge core_clk_in);
        rstn_in <= 1'b1;
        repeat (3) @(posedge core_clk_in);
    endtask

    task automatic wa(input logic [11:0] ad, input logic [35:0] wd, input logic [3:0] m, input logic h,
                      output logic [35:0] r);
        i_fab.cycle(mk(ad, wd, 1'b1, 1'b0, m, h), nob, lat, r, d);
    endtask

    task automatic rda(input logic [11:0] ad, output logic [35:0] r);
        i_fab.cycle(mk(ad, 36'h0, 1'b0, 1'b1, 4'hf, 1'b0), nob, lat, r, d);
    endtask

    task automatic s_mask();
        logic [35:0] r;
        logic [35:0] bm;
        bm = m9(4'h5);
        wa(12'h005, 36'h123456789, 4'hf, 1'b0, r);
        `CHECK_EQ("flow write", 36'h123456789, r)
        wa(12'h005, 36'hfedcba987, 4'h5, 1'b0, r);
        `CHECK_EQ("masked flow", 36'hfedcba987 & bm, r & bm)
        rda(12'h005, r);
        `CHECK_EQ("masked store", (36'hfedcba987 & bm) | (36'h123456789 & ~bm), r)
        wa(12'h005, 36'h0, 4'h0, 1'b0, r);
        i_fab.cycle(mk(12'h005, 36'h0, 1'b0, 1'b0, 4'hf, 1'b0), nob, lat, r, d);
        rda(12'h005, r);
        `CHECK_EQ("no write", (36'hfedcba987 & bm) | (36'h123456789 & ~bm), r)
    endtask

    task automatic s_hold();
        logic [35:0] r;
        wa(12'h007, 36'h0aaaaaaaa, 4'hf, 1'b0, r);
        wa(12'h009, 36'h0bbbbbbbb, 4'hf, 1'b0, r);
        wa(12'h007, 36'h0cccccccc, 4'hf, 1'b1, r);
        rda(12'h009, r);
        `CHECK_EQ("held write", 36'h0cccccccc, r)
        rda(12'h007, r);
        `CHECK_EQ("hold low", 36'h0aaaaaaaa, r)
    endtask

    task automatic s_enable();
        logic [35:0] r;
        @(posedge core_clk_in);
        block_en_in <= 1'b0;
        wa(12'h007, 36'h0dddddddd, 4'hf, 1'b0, r);
        @(posedge core_clk_in);
        block_en_in <= 1'b1;
        rda(12'h007, r);
        `CHECK_EQ("gated write", 36'h0aaaaaaaa, r)
    endtask

    task automatic s_pipe();
        logic [35:0] r;
        cfg(mode_single, `W_X36, 1'b1);
        wa(12'h003, 36'h9c0ffee11, 4'hf, 1'b0, r);
        rda(12'h003, r);
        `CHECK_EQ("pipelined read", 36'h9c0ffee11, r)
        @(posedge core_clk_in);
        out_clr_in <= 1'b1;
        #1;
        `CHECK_EQ("output clear", 36'h0, rdata_a_out)
        @(posedge core_clk_in);
        out_clr_in <= 1'b0;
        rda(12'h003, r);
        `CHECK_EQ("array kept", 36'h9c0ffee11, r)
    endtask

    task automatic s_dual();
        logic [35:0] ra;
        logic [35:0] rb;
        cfg(mode_true_dual, `W_X16, 1'b0);
        i_fab.cycle(mk(12'h002, 36'h0, 1'b1, 1'b0, 4'hf, 1'b0), mk(12'h00a, 36'h0, 1'b1, 1'b0, 4'h0, 1'b0), 0, ra, rb);
        i_fab.cycle(mk(12'h002, 36'h0abcd, 1'b1, 1'b0, 4'h6, 1'b0), mk(12'h00a, 36'h01234, 1'b1, 1'b0, 4'hf, 1'b0),
                    0, ra, rb);
        i_fab.cycle(mk(12'h002, 36'h0, 1'b0, 1'b1, 4'hf, 1'b0), mk(12'h00a, 36'h0, 1'b0, 1'b1, 4'hf, 1'b0), 0, ra, rb);
        `CHECK_EQ("port a lanes", 36'h0ab00, ra & 36'h0ffff)
        `CHECK_EQ("port b lanes", 36'h00034, rb & 36'h0ffff)
        i_fab.cycle(mk(12'h00a, 36'h0, 1'b0, 1'b1, 4'hf, 1'b0), mk(12'h002, 36'h0, 1'b0, 1'b1, 4'hf, 1'b1), 0, ra, rb);
        `CHECK_EQ("port b hold", 36'h00034, rb & 36'h0ffff)
        `CHECK_EQ("port a moves", 36'h00034, ra & 36'h0ffff)
    endtask

    task automatic s_packed();
        logic [35:0] ra;
        logic [35:0] rb;
        cfg(mode_packed, `W_X18, 1'b0);
        i_fab.cycle(mk(12'h004, 36'h11111, 1'b1, 1'b0, 4'hf, 1'b0), mk(12'h004, 36'h22222, 1'b1, 1'b0, 4'hf, 1'b0), 0, ra, rb);
        i_fab.cycle(mk(12'h004, 36'h0, 1'b0, 1'b1, 4'hf, 1'b0), mk(12'h004, 36'h0, 1'b0, 1'b1, 4'hf, 1'b0), 0, ra, rb);
        `CHECK_EQ("packed a", 36'h11111, ra & 36'h3ffff)
        `CHECK_EQ("packed b", 36'h22222, rb & 36'h3ffff)
    endtask

    task automatic tally_and_finish();
        if (errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        rstn_in = 1'b0;
        block_en_in = 1'b1;
        out_clr_in = 1'b0;
        out_reg_en_in = 1'b0;
        mode_in = mode_single;
        width_a_in = `W_X36;
        width_b_in = `W_X36;
        nob = mk(12'h000, 36'h0, 1'b0, 1'b0, 4'hf, 1'b0);
        cfg(mode_single, `W_X36, 1'b0);
        s_mask();
        s_hold();
        s_enable();
        s_pipe();
        s_dual();
        s_packed();
        tally_and_finish();
    end

    // watchdog
    initial begin
        #100000;
        errors++;
        tally_and_finish();
    end
endmodule
